// *** src/tmc_pkg.sv ***
package tmc_pkg;
  // register indices on the byte-wide port
  localparam logic [2:0] ADDR_SC   = 3'h0;
  localparam logic [2:0] ADDR_CNTH = 3'h1;
  localparam logic [2:0] ADDR_CNTL = 3'h2;
  localparam logic [2:0] ADDR_MODH = 3'h3;
  localparam logic [2:0] ADDR_MODL = 3'h4;
  // status/control field positions
  localparam int SC_FLAG_BIT = 7;
  localparam int SC_IRQE_BIT = 6;
  localparam int SC_CALN_BIT = 5;
  localparam int SC_CLKS_HI  = 4;
  localparam int SC_CLKS_LO  = 3;
  localparam int SC_PS_HI    = 2;
  // clock source codes
  localparam logic [1:0] CLKS_OFF = 2'h0;
  localparam logic [1:0] CLKS_BUS = 2'h1;
  localparam logic [1:0] CLKS_FIX = 2'h2;
  localparam logic [1:0] CLKS_EXT = 2'h3;
  // reset values and count limit
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] MOD_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } tmc_req_t;
endpackage

// *** src/tmc_core.sv ***
`timescale 1ns/10ps
module tmc_core
  import tmc_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int PS_W  = 3
)(
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             srst_i,
  // register port
  input  wire tmc_req_t         req_i,
  output logic      [7:0]       rdata_o,
  // clock sources from outside the domain
  input  wire logic             fixed_system_clock_i,
  input  wire logic             ext_timer_clock_i,
  // debug freeze
  input  wire logic             bdm_active_i,
  // outputs to channels and system
  output logic                  irq_o,
  output logic                  center_aligned_pwm_o,
  output logic      [CNT_W-1:0] count_o,
  output logic                  tick_o
);
  // control and status state
  logic             overflow_flag_r;
  logic             flag_armed_r;     // read seen while flag set
  logic             overflow_irq_enable_r;
  logic             center_align_select_r;
  logic [1:0]       clock_source_select_r;
  logic [PS_W-1:0]  prescale_select_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] mod_r;
  logic             down_r;           // counting down in centre mode
  logic             mod_half_r;       // one modulo byte written
  logic             mod_hi_r;         // pending byte was the high one
  logic [CNT_W-1:0] latch_r;          // coherent read buffer
  logic             latched_r;
  logic [6:0]       pre_r;            // prescaler counter
  logic [2:0]       fix_sync_r;       // three stage synchronisers
  logic [2:0]       ext_sync_r;
  logic             fix_lvl_r;        // agreed levels
  logic             ext_lvl_r;

  // decoded accesses
  wire wr_sc   = req_i.wr && req_i.addr == ADDR_SC;
  wire wr_cnt  = req_i.wr &&
                 (req_i.addr == ADDR_CNTH || req_i.addr == ADDR_CNTL);
  wire wr_modh = req_i.wr && req_i.addr == ADDR_MODH;
  wire wr_modl = req_i.wr && req_i.addr == ADDR_MODL;
  wire rd_sc   = req_i.rd && req_i.addr == ADDR_SC;
  wire rd_cnt  = req_i.rd &&
                 (req_i.addr == ADDR_CNTH || req_i.addr == ADDR_CNTL);

  // synchronisers: stage 0 read only by stage 1
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      fix_sync_r <= 3'h0;
      ext_sync_r <= 3'h0;
      fix_lvl_r  <= 1'b0;
      ext_lvl_r  <= 1'b0;
    end
    else
    begin
      fix_sync_r <= {fix_sync_r[1:0], fixed_system_clock_i};
      ext_sync_r <= {ext_sync_r[1:0], ext_timer_clock_i};
      // a change counts when stages one and two agree
      if (fix_sync_r[1] == fix_sync_r[2])
        fix_lvl_r <= fix_sync_r[2];
      if (ext_sync_r[1] == ext_sync_r[2])
        ext_lvl_r <= ext_sync_r[2];
    end
  end

  // rising edges of agreed levels
  wire fix_rise = (fix_sync_r[2] == fix_sync_r[1]) && fix_sync_r[2]
                  && !fix_lvl_r;
  wire ext_rise = (ext_sync_r[2] == ext_sync_r[1]) && ext_sync_r[2]
                  && !ext_lvl_r;

  logic src_tick;
  always_comb
  begin
    case (clock_source_select_r)
      CLKS_OFF: src_tick = 1'b0;
      CLKS_BUS: src_tick = 1'b1;
      CLKS_FIX: src_tick = fix_rise;
      CLKS_EXT: src_tick = ext_rise;
      default:  src_tick = 1'b0;
    endcase
  end

  function automatic logic [6:0] ps_mask(input logic [PS_W-1:0] ps);
    ps_mask = 7'((8'h01 << ps) - 8'h01);
  endfunction

  wire run      = !bdm_active_i;
  wire pre_done = (pre_r & ps_mask(prescale_select_r)) ==
                  ps_mask(prescale_select_r);
  wire tick     = src_tick && pre_done && run;

  // prescaler counter
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || wr_sc)
      pre_r <= 7'h00;
    else if (src_tick && run)
      pre_r <= pre_done ? 7'h00 : pre_r + 7'h01;
  end

  // zero or all ones means full range
  wire             mod_off = (mod_r == MOD_RST) || (mod_r == CNT_MAX);
  wire [CNT_W-1:0] top     = mod_off ? CNT_W'(CNT_MAX) : mod_r;
  wire             at_top  = cnt_r == top;
  wire             at_zero = cnt_r == CNT_W'(CNT_RST);

  // next count and overflow event
  logic [CNT_W-1:0] cnt_nxt;
  logic             down_nxt;
  logic             ovf_evt;
  always_comb
  begin
    cnt_nxt  = cnt_r;
    down_nxt = down_r;
    ovf_evt  = 1'b0;
    if (!center_align_select_r)
    begin
      down_nxt = 1'b0;
      if (at_top)
      begin
        cnt_nxt = CNT_W'(CNT_RST);
        ovf_evt = 1'b1;
      end
      else
        cnt_nxt = cnt_r + CNT_W'(1);
    end
    else if (!down_r)
    begin
      if (at_top)
      begin
        cnt_nxt  = cnt_r - CNT_W'(1);
        down_nxt = 1'b1;
        ovf_evt  = 1'b1;
      end
      else
        cnt_nxt = cnt_r + CNT_W'(1);
    end
    else
    begin
      if (at_zero)
      begin
        cnt_nxt  = cnt_r + CNT_W'(1);
        down_nxt = 1'b0;
      end
      else
        cnt_nxt = cnt_r - CNT_W'(1);
    end
  end

  // flag held off while modulo half written
  wire ovf_set = tick && ovf_evt && !mod_half_r;

  // main counter
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || wr_cnt)
    begin
      cnt_r  <= CNT_W'(CNT_RST);
      down_r <= 1'b0;
    end
    // freeze in debug via tick; one step per tick
    else if (tick)
    begin
      cnt_r  <= cnt_nxt;
      down_r <= down_nxt;
    end
  end

  // modulo register and half-write tracker
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      mod_r      <= CNT_W'(MOD_RST);
      mod_half_r <= 1'b0;
      mod_hi_r   <= 1'b0;
    end
    else if (wr_modh || wr_modl)
    begin
      if (wr_modh)
        mod_r[15:8] <= req_i.wdata;
      else
        mod_r[7:0]  <= req_i.wdata;
      // only the other byte completes the pair
      if (mod_half_r && (mod_hi_r != wr_modh))
        mod_half_r <= 1'b0;
      else
      begin
        mod_half_r <= 1'b1;
        mod_hi_r   <= wr_modh;
      end
    end
  end

  // control fields
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      overflow_irq_enable_r <= 1'b0;
      center_align_select_r <= 1'b0;
      clock_source_select_r <= CLKS_OFF;
      prescale_select_r     <= '0;
    end
    else if (wr_sc)
    begin
      overflow_irq_enable_r <= req_i.wdata[SC_IRQE_BIT];
      center_align_select_r <= req_i.wdata[SC_CALN_BIT];
      clock_source_select_r <= req_i.wdata[SC_CLKS_HI:SC_CLKS_LO];
      prescale_select_r     <= req_i.wdata[SC_PS_HI:0];
    end
  end

  // overflow flag and clear sequence
  wire clr_ok = wr_sc && !req_i.wdata[SC_FLAG_BIT] && flag_armed_r;
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      overflow_flag_r <= 1'b0;
      flag_armed_r    <= 1'b0;
    end
    else if (ovf_set)
    begin
      overflow_flag_r <= 1'b1;
      flag_armed_r    <= 1'b0;
    end
    // clear after armed read; a one does nothing
    else if (clr_ok)
    begin
      overflow_flag_r <= 1'b0;
      flag_armed_r    <= 1'b0;
    end
    else if (rd_sc && overflow_flag_r)
      flag_armed_r <= 1'b1;
  end

  // coherent read latch
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || wr_cnt || wr_sc)
    begin
      latched_r <= 1'b0;
      latch_r   <= CNT_W'(CNT_RST);
    end
    else if (rd_cnt && run)
    begin
      if (!latched_r)
        latch_r <= cnt_r;
      latched_r <= !latched_r;
    end
  end

  // read data selection
  wire [CNT_W-1:0] cnt_view = latched_r ? latch_r : cnt_r;
  wire [7:0] sc_view = {overflow_flag_r, overflow_irq_enable_r,
                        center_align_select_r, clock_source_select_r,
                        prescale_select_r};
  logic [7:0] rd_mux;
  always_comb
  begin
    case (req_i.addr)
      ADDR_SC:   rd_mux = sc_view;
      ADDR_CNTH: rd_mux = cnt_view[15:8];
      ADDR_CNTL: rd_mux = cnt_view[7:0];
      ADDR_MODH: rd_mux = mod_r[15:8];
      ADDR_MODL: rd_mux = mod_r[7:0];
      default:   rd_mux = BYTE_ZERO;
    endcase
  end

  // registered outputs
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      rdata_o              <= BYTE_ZERO;
      irq_o                <= 1'b0;
      center_aligned_pwm_o <= 1'b0;
      count_o              <= CNT_W'(CNT_RST);
      tick_o               <= 1'b0;
    end
    else
    begin
      rdata_o              <= req_i.rd ? rd_mux : BYTE_ZERO;
      irq_o                <= overflow_flag_r && overflow_irq_enable_r;
      center_aligned_pwm_o <= center_align_select_r;
      count_o              <= cnt_r;
      tick_o               <= tick;
    end
  end

  // checks
  a_flag_on_wrap:
    assert property (@(posedge core_clk_i) disable iff (srst_i)
      tick && !center_align_select_r && at_top && !mod_half_r
      |=> overflow_flag_r && cnt_r == 16'h0000)
    else $error("flag not set at wrap");
  a_centre_turn:
    assert property (@(posedge core_clk_i) disable iff (srst_i)
      tick && center_align_select_r && !down_r && at_top && !wr_cnt
      |=> down_r && cnt_r == $past(cnt_r) - 16'h0001)
    else $error("centre turn wrong");
  a_clear_needs_read:
    assert property (@(posedge core_clk_i) disable iff (srst_i)
      $fell(overflow_flag_r) |-> $past(flag_armed_r))
    else $error("flag cleared without read");
  a_set_beats_clear:
    assert property (@(posedge core_clk_i) disable iff (srst_i)
      ovf_set |=> overflow_flag_r && !flag_armed_r)
    else $error("overflow lost");
  a_irq_follows:
    assert property (@(posedge core_clk_i) disable iff (srst_i)
      overflow_flag_r && overflow_irq_enable_r ##1 !srst_i |-> irq_o)
    else $error("irq missing");
  a_cnt_write_zero:
    assert property (@(posedge core_clk_i) disable iff (srst_i)
      wr_cnt |=> cnt_r == 16'h0000 && !latched_r)
    else $error("counter not zeroed");
  a_freeze_debug:
    assert property (@(posedge core_clk_i) disable iff (srst_i)
      bdm_active_i && !wr_cnt && !wr_sc
      |=> $stable(cnt_r) && $stable(latched_r))
    else $error("not frozen in debug");
  a_mod_suppress:
    assert property (@(posedge core_clk_i) disable iff (srst_i)
      mod_half_r && !overflow_flag_r && !req_i.wr |=> !overflow_flag_r)
    else $error("flag during half modulo");
  a_off_no_count:
    assert property (@(posedge core_clk_i) disable iff (srst_i)
      clock_source_select_r == CLKS_OFF && !wr_cnt |=> $stable(cnt_r))
    else $error("counted while disabled");
endmodule // tmc_core

// *** testbench/test_tmc_core.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
module test_tmc_core
  import tmc_pkg::*;
;
  // clock, reset and stimulus
  logic        core_clk_i = 1'b0;
  logic        srst_i     = 1'b1;
  tmc_req_t    req_i      = '0;
  logic        fixed_system_clock_i = 1'b0;
  logic        ext_timer_clock_i    = 1'b0;
  logic        bdm_active_i         = 1'b0;
  // observed outputs
  logic [7:0]  rdata_o;
  logic        irq_o;
  logic        center_aligned_pwm_o;
  logic [15:0] count_o;
  logic        tick_o;
  // bench state
  int          err_total  = 0;
  int          n_compared = 0;
  logic [2:0]  fc         = 3'h0;
  int          ec         = 0;
  logic [7:0]  d;
  logic [15:0] c;
  logic [15:0] mx;
  logic        dn;
  int          n;
  logic [7:0]  sc_tab [11] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D,
                               8'h0E, 8'h0F, 8'h10, 8'h18, 8'h19};
  int          gap_tab [11] = '{1, 2, 4, 8, 16, 32, 64, 128, 8, 12, 24};

  tmc_core uut (
    .core_clk_i           (core_clk_i),
    .srst_i               (srst_i),
    .req_i                (req_i),
    .rdata_o              (rdata_o),
    .fixed_system_clock_i (fixed_system_clock_i),
    .ext_timer_clock_i    (ext_timer_clock_i),
    .bdm_active_i         (bdm_active_i),
    .irq_o                (irq_o),
    .center_aligned_pwm_o (center_aligned_pwm_o),
    .count_o              (count_o),
    .tick_o               (tick_o)
  );

  // 10 mhz core clock
  always #50 core_clk_i = ~core_clk_i;

  // slow sources: fixed period 8, external period 12 (quarter rate or less)
  // ext slow enough
  always @(posedge core_clk_i)
  begin
    fc <= fc + 3'h1;
    fixed_system_clock_i <= fc[2];
    ec <= (ec == 11) ? 0 : ec + 1;
    ext_timer_clock_i <= (ec < 6);
  end

  // verdict and end of run
  task automatic finish_test();
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    req_i.wr    <= 1'b1;
    req_i.addr  <= a;
    req_i.wdata <= v;
    @(posedge core_clk_i);
    req_i.wr    <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge core_clk_i);
    req_i.rd   <= 1'b1;
    req_i.addr <= a;
    @(posedge core_clk_i);
    req_i.rd   <= 1'b0;
    #1 v = rdata_o;
  endtask

  // cycles from one counter step to the next
  task automatic gap(output int g);
    int i;
    g = 0;
    for (i = 0; i < 400 && tick_o !== 1'b1; i++)
      @(posedge core_clk_i) #1;
    do
    begin
      @(posedge core_clk_i) #1;
      g++;
    end while (tick_o !== 1'b1 && g < 400);
  endtask

  // poll status until the overflow flag shows
  task automatic wait_flag();
    int i;
    d = 8'h00;
    for (i = 0; i < 2000 && d[7] !== 1'b1; i++)
      rd(ADDR_SC, d);
  endtask

  // track peak count and any step down by one
  task automatic watch(input int cyc);
    logic [15:0] pv;
    mx = 16'h0000;
    dn = 1'b0;
    pv = count_o;
    repeat (cyc)
    begin
      @(posedge core_clk_i) #1;
      if (count_o > mx) mx = count_o;
      if (count_o + 16'h0001 == pv) dn = 1'b1;
      pv = count_o;
    end
  endtask

  // hang guard, well beyond the longest sequence
  initial
  begin
    #4_000_000;
    err_total++;
    finish_test();
  end

  // main sequence
  initial
  begin
    repeat (8) @(posedge core_clk_i);
    srst_i <= 1'b0;
    for (int a = 0; a < 6; a++)
    begin
      rd(a[2:0], d);
      `CHK("reset reg", 8'h00, d)
    end
    `CHK("reset irq", 1'b0, irq_o)
    // ext pin is not shared with a channel here
    for (int k = 0; k < 11; k++)
    begin
      wr(ADDR_SC, sc_tab[k]);
      gap(n);
      gap(n);
      `CHK("tick gap", gap_tab[k], n)
    end
    wr(ADDR_SC, 8'h00);
    repeat (2) @(posedge core_clk_i);
    #1 c = count_o;
    repeat (20) @(posedge core_clk_i);
    `CHK("clock off", c, count_o)
    wr(ADDR_CNTL, 8'h00);
    wr(ADDR_MODH, 8'h00);
    wr(ADDR_MODL, 8'h05);
    wr(ADDR_SC, 8'h08);
    watch(60);
    `CHK("up peak", 16'h0005, mx)
    `CHK("up no down", 1'b0, dn)
    rd(ADDR_SC, d);
    `CHK("up flag", 1'b1, d[7])
    wr(ADDR_SC, 8'h00);
    rd(ADDR_SC, d);
    `CHK("flag cleared", 1'b0, d[7])
    wr(ADDR_SC, 8'h80);
    rd(ADDR_SC, d);
    `CHK("write one", 8'h00, d)
    wr(ADDR_SC, 8'h4F);
    wait_flag();
    `CHK("flag seen", 1'b1, d[7])
    repeat (2) @(posedge core_clk_i);
    `CHK("irq on flag", 1'b1, irq_o)
    repeat (790) @(posedge core_clk_i);
    wr(ADDR_SC, 8'h4F);
    rd(ADDR_SC, d);
    `CHK("rearmed flag", 1'b1, d[7])
    wr(ADDR_SC, 8'h00);
    repeat (2) @(posedge core_clk_i);
    rd(ADDR_SC, d);
    `CHK("flag after clear", 1'b0, d[7])
    `CHK("irq after clear", 1'b0, irq_o)
    wr(ADDR_MODH, 8'h00);
    wr(ADDR_SC, 8'h08);
    repeat (100) @(posedge core_clk_i);
    rd(ADDR_SC, d);
    `CHK("half modulo", 1'b0, d[7])
    wr(ADDR_MODL, 8'h05);
    repeat (40) @(posedge core_clk_i);
    rd(ADDR_SC, d);
    `CHK("full modulo", 1'b1, d[7])
    wr(ADDR_SC, 8'h00);
    wr(ADDR_SC, 8'h28);
    @(posedge core_clk_i) #1;
    `CHK("center out", 1'b1, center_aligned_pwm_o)
    watch(60);
    `CHK("center peak", 16'h0005, mx)
    `CHK("center down", 1'b1, dn)
    rd(ADDR_SC, d);
    `CHK("center flag", 1'b1, d[7])
    wr(ADDR_MODH, 8'h00);
    wr(ADDR_MODL, 8'h00);
    wr(ADDR_SC, 8'h08);
    wr(ADDR_CNTH, 8'hA5);
    rd(ADDR_CNTH, d);
    `CHK("zeroed high", 8'h00, d)
    repeat (300) @(posedge core_clk_i);
    rd(ADDR_CNTL, d);
    `CHK("latched low", 1'b1, d < 8'h08)
    rd(ADDR_CNTH, d);
    repeat (300) @(posedge core_clk_i);
    wr(ADDR_CNTL, 8'h5A);
    rd(ADDR_CNTL, d);
    `CHK("latch restart", 1'b1, d < 8'h08)
    @(posedge core_clk_i);
    bdm_active_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    c = count_o;
    repeat (50) @(posedge core_clk_i);
    `CHK("debug freeze", c, count_o)
    bdm_active_i <= 1'b0;
    finish_test();
  end
endmodule // test_tmc_core
